/* File: logic/tlfr_top.sv */
// Purpose: Temperature thresholds and cold-trip fault response of a power stage
// Assumes: Command port decoded upstream; temperature samples in Linear format
// Notes: Delay unit enters as a cycle count; status register code is a local choice
`default_nettype none

module tlfr_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Command port
	input wire logic cmd_valid_in,
	input wire logic cmd_write_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	input wire logic clear_faults_in,
	output logic cmd_ack_out,
	output logic cmd_err_out,
	output logic [15:0] cmd_rdata_out,
	// Measurement and control
	input wire logic temp_valid_in,
	input wire logic [15:0] temp_in,
	input wire logic on_off_in,
	input wire logic other_shutdown_in,
	input wire logic [tlfr_pkg::UNIT_W-1:0] unit_len_in,
	// Results
	output logic out_enable_out,
	output logic [2:0] status_out
);

	typedef struct packed {
		logic [15:0] hot_thr;
		logic [15:0] cold_thr;
		logic [15:0] trip_thr;
		logic [7:0] action;
		logic [2:0] status;
		logic cold_now;
		logic on_meta;
		logic on_sync;
		logic on_prev;
		tlfr_pkg::tlfr_fsm_e fsm;
		logic [2:0] attempts;
		logic [tlfr_pkg::UNIT_W-1:0] unit_cnt;
		logic [tlfr_pkg::DLY_W-1:0] dly_cnt;
		logic out_en;
		logic ack;
		logic err;
		logic [15:0] rdata;
	} tlfr_regs_s;

	tlfr_regs_s regs_reg;
	tlfr_regs_s regs_next;

	////////////////////////////////////////////////////////////////////////////
	// Linear value to signed fixed point scaled by 2^16
	function automatic logic signed [42:0] tlfr_lin_fix(input logic [15:0] v);
		logic [4:0] sh;
		logic signed [42:0] m;
		sh = {~v[15], v[14:11]};
		m = $signed({{32{v[10]}}, v[10:0]});
		return m <<< sh;
	endfunction : tlfr_lin_fix

	logic signed [42:0] temp_fix;
	logic hot_hit;
	logic cold_hit;
	logic trip_hit;
	logic [1:0] mode;
	logic [2:0] retry;
	logic [2:0] dly_sel;
	logic [tlfr_pkg::DLY_W-1:0] dly_load;
	logic unit_tick;
	logic dly_done;
	logic wr_hit;
	logic rd_hit;
	logic [2:0] set_vec;
	logic [2:0] clr_vec;
	logic fault_clear;
	logic on_rise;
	logic trip_evt;
	logic may_retry;

	always_comb begin
		temp_fix = tlfr_lin_fix(temp_in);
		hot_hit = temp_fix > tlfr_lin_fix(regs_reg.hot_thr);
		cold_hit = temp_fix < tlfr_lin_fix(regs_reg.cold_thr);
		trip_hit = temp_fix < tlfr_lin_fix(regs_reg.trip_thr);
		mode = regs_reg.action[tlfr_pkg::MODE_HI:tlfr_pkg::MODE_LO];
		retry = regs_reg.action[tlfr_pkg::RETRY_HI:tlfr_pkg::RETRY_LO];
		dly_sel = regs_reg.action[tlfr_pkg::DELAY_HI:tlfr_pkg::DELAY_LO];
		dly_load = (tlfr_pkg::DLY_ONE << dly_sel) - tlfr_pkg::DLY_ONE;
		unit_tick = (unit_len_in == '0) || (regs_reg.unit_cnt >= unit_len_in - 24'h1);
		dly_done = unit_tick && (regs_reg.dly_cnt == '0);
		wr_hit = cmd_valid_in && cmd_write_in;
		rd_hit = cmd_valid_in && !cmd_write_in;
		set_vec = {trip_hit, cold_hit, hot_hit} & {3{temp_valid_in}};
		clr_vec = {3{clear_faults_in}};
		if (wr_hit && cmd_code_in == tlfr_pkg::CODE_STATUS) begin
			clr_vec = clr_vec | cmd_wdata_in[2:0];
		end
		on_rise = regs_reg.on_sync && !regs_reg.on_prev;
		fault_clear = clr_vec[tlfr_pkg::ST_COLD_FAULT] || on_rise;
		trip_evt = regs_reg.cold_now && regs_reg.on_sync;
		may_retry = (retry != tlfr_pkg::RETRY_NONE) && ((retry == tlfr_pkg::RETRY_FOREVER)
			|| (regs_reg.attempts < retry));
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		regs_next = regs_reg;
		regs_next.ack = 1'b0;
		regs_next.err = 1'b0;
		regs_next.on_meta = on_off_in;
		regs_next.on_sync = regs_reg.on_meta;
		regs_next.on_prev = regs_reg.on_sync;
		if (temp_valid_in) begin
			regs_next.cold_now = trip_hit;
		end
		// Set beats clear in the same cycle
		regs_next.status = (regs_reg.status & ~clr_vec) | set_vec;
		// Command port
		if (cmd_valid_in) begin
			regs_next.ack = 1'b1;
			regs_next.rdata = 16'h0000;
			unique case (cmd_code_in)
				tlfr_pkg::CODE_HOT_ALERT: begin
					if (wr_hit) regs_next.hot_thr = cmd_wdata_in;
					regs_next.rdata = regs_reg.hot_thr;
				end
				tlfr_pkg::CODE_COLD_ALERT: begin
					if (wr_hit) regs_next.cold_thr = cmd_wdata_in;
					regs_next.rdata = regs_reg.cold_thr;
				end
				tlfr_pkg::CODE_COLD_TRIP: begin
					if (wr_hit) regs_next.trip_thr = cmd_wdata_in;
					regs_next.rdata = regs_reg.trip_thr;
				end
				tlfr_pkg::CODE_COLD_ACTION: begin
					if (wr_hit) regs_next.action = cmd_wdata_in[7:0];
					regs_next.rdata = {8'h00, regs_reg.action};
				end
				tlfr_pkg::CODE_STATUS: begin
					regs_next.rdata = {13'h0000, regs_reg.status};
				end
				default: begin
					regs_next.err = 1'b1;
				end
			endcase
			if (!rd_hit) begin
				regs_next.rdata = 16'h0000;
			end
		end
		// Unit divider
		regs_next.unit_cnt = unit_tick ? '0 : regs_reg.unit_cnt + 24'h1;
		if (unit_tick && regs_reg.dly_cnt != '0) begin
			regs_next.dly_cnt = regs_reg.dly_cnt - tlfr_pkg::DLY_ONE;
		end
		// Fault response machine
		unique case (regs_reg.fsm)
			tlfr_pkg::FSM_RUN: begin
				if (trip_evt) begin
					unique case (mode)
						tlfr_pkg::MODE_IGNORE: begin
							regs_next.fsm = tlfr_pkg::FSM_RUN;
						end
						tlfr_pkg::MODE_RUN_DELAY: begin
							regs_next.fsm = tlfr_pkg::FSM_GRACE;
							regs_next.dly_cnt = dly_load;
							regs_next.unit_cnt = '0;
						end
						tlfr_pkg::MODE_OFF_RETRY: begin
							regs_next.fsm = may_retry ? tlfr_pkg::FSM_WAIT
								: tlfr_pkg::FSM_LATCH;
							regs_next.dly_cnt = dly_load;
							regs_next.unit_cnt = '0;
						end
						tlfr_pkg::MODE_OFF_LATCH: begin
							regs_next.fsm = tlfr_pkg::FSM_LATCH;
						end
					endcase
				end
			end
			tlfr_pkg::FSM_GRACE: begin
				if (dly_done) begin
					if (!regs_reg.cold_now) begin
						regs_next.fsm = tlfr_pkg::FSM_RUN;
					end else begin
						regs_next.fsm = may_retry ? tlfr_pkg::FSM_WAIT
							: tlfr_pkg::FSM_LATCH;
						regs_next.dly_cnt = dly_load;
						regs_next.unit_cnt = '0;
					end
				end
			end
			tlfr_pkg::FSM_WAIT: begin
				if (dly_done) begin
					regs_next.fsm = tlfr_pkg::FSM_RUN;
					if (retry != tlfr_pkg::RETRY_FOREVER) begin
						regs_next.attempts = regs_reg.attempts + 3'h1;
					end
				end
			end
			tlfr_pkg::FSM_LATCH: begin
				regs_next.fsm = tlfr_pkg::FSM_LATCH;
			end
			default: begin
				regs_next.fsm = tlfr_pkg::FSM_LATCH;
			end
		endcase
		if (fault_clear || !regs_reg.on_sync) begin
			regs_next.fsm = tlfr_pkg::FSM_RUN;
			regs_next.attempts = 3'h0;
		end
		if (other_shutdown_in) begin
			regs_next.fsm = tlfr_pkg::FSM_LATCH;
		end
		regs_next.out_en = regs_reg.on_sync && (regs_next.fsm == tlfr_pkg::FSM_RUN
			|| regs_next.fsm == tlfr_pkg::FSM_GRACE);
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			regs_reg <= '{
				hot_thr: tlfr_pkg::RST_HOT_ALERT,
				cold_thr: tlfr_pkg::RST_COLD_ALERT,
				trip_thr: tlfr_pkg::RST_COLD_TRIP,
				action: tlfr_pkg::RST_COLD_ACTION,
				fsm: tlfr_pkg::FSM_RUN,
				default: '0
			};
		end else begin
			regs_reg <= regs_next;
		end
	end

	assign cmd_ack_out = regs_reg.ack;
	assign cmd_err_out = regs_reg.err;
	assign cmd_rdata_out = regs_reg.rdata;
	assign out_enable_out = regs_reg.out_en;
	assign status_out = regs_reg.status;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	a_hot_write: assert property (wr_hit && cmd_code_in == tlfr_pkg::CODE_HOT_ALERT
		|=> regs_reg.hot_thr == $past(cmd_wdata_in)) else $error("hot threshold lost");
	a_cold_write: assert property (wr_hit && cmd_code_in == tlfr_pkg::CODE_COLD_ALERT
		|=> regs_reg.cold_thr == $past(cmd_wdata_in)) else $error("cold threshold lost");
	a_trip_readback: assert property (wr_hit && cmd_code_in == tlfr_pkg::CODE_COLD_TRIP
		##1 rd_hit && cmd_code_in == tlfr_pkg::CODE_COLD_TRIP
		|=> cmd_rdata_out == $past(cmd_wdata_in, 2)) else $error("trip readback wrong");
	a_action_byte: assert property (wr_hit && cmd_code_in == tlfr_pkg::CODE_COLD_ACTION
		|=> regs_reg.action == $past(cmd_wdata_in[7:0])) else $error("action byte lost");
	a_ignore_mode: assert property (regs_reg.fsm == tlfr_pkg::FSM_RUN && trip_evt
		&& mode == 2'b00 && !other_shutdown_in |=> out_enable_out)
		else $error("ignored fault cut output");
	a_grace_runs: assert property (regs_reg.fsm == tlfr_pkg::FSM_RUN && trip_evt
		&& mode == 2'b01 && !other_shutdown_in && !fault_clear
		|=> regs_reg.fsm == tlfr_pkg::FSM_GRACE && out_enable_out)
		else $error("run-on not entered");
	a_off_at_once: assert property (regs_reg.fsm == tlfr_pkg::FSM_RUN && trip_evt
		&& mode == 2'b10 && !fault_clear |=> !out_enable_out) else $error("output not cut");
	a_latch_mode: assert property (regs_reg.fsm == tlfr_pkg::FSM_RUN && trip_evt
		&& mode == 2'b11 && !fault_clear |=> regs_reg.fsm == tlfr_pkg::FSM_LATCH)
		else $error("no latch on mode 11");
	a_clear_exit: assert property (regs_reg.fsm == tlfr_pkg::FSM_LATCH && clear_faults_in
		&& !other_shutdown_in |=> regs_reg.fsm == tlfr_pkg::FSM_RUN)
		else $error("latched fault not cleared");
	a_retry_bound: assert property (regs_reg.fsm == tlfr_pkg::FSM_WAIT
		&& retry != tlfr_pkg::RETRY_FOREVER |-> regs_reg.attempts < retry)
		else $error("too many restarts");
	a_wait_spacing: assert property ($rose(regs_reg.fsm == tlfr_pkg::FSM_WAIT)
		&& unit_len_in == 24'h1 && dly_sel == 3'h2 && regs_reg.on_sync
		&& !other_shutdown_in && !clear_faults_in
		##1 (regs_reg.on_sync && !other_shutdown_in && !clear_faults_in) [*3]
		|=> regs_reg.fsm == tlfr_pkg::FSM_RUN) else $error("restart spacing wrong");
	a_forever_retry: assert property (regs_reg.fsm == tlfr_pkg::FSM_RUN && trip_evt
		&& mode == 2'b10 && retry == tlfr_pkg::RETRY_FOREVER && !other_shutdown_in
		|=> regs_reg.fsm != tlfr_pkg::FSM_LATCH) else $error("endless retry stopped");
	a_sticky_set: assert property (temp_valid_in && trip_hit
		|=> status_out[tlfr_pkg::ST_COLD_FAULT]) else $error("set lost to clear");

	c_grace: cover property (regs_reg.fsm == tlfr_pkg::FSM_GRACE ##1
		regs_reg.fsm == tlfr_pkg::FSM_WAIT);
	c_latch: cover property (regs_reg.fsm == tlfr_pkg::FSM_LATCH ##1
		regs_reg.fsm == tlfr_pkg::FSM_RUN);
	c_restart: cover property (regs_reg.fsm == tlfr_pkg::FSM_WAIT ##1
		regs_reg.fsm == tlfr_pkg::FSM_RUN && regs_reg.attempts == 3'h1);

endmodule : tlfr_top

`default_nettype wire

/* File: logic/tlfr_pkg.sv */
// Purpose: Shared constants and types of the temperature limit and fault response block
// Assumes: One 50 MHz clock, synchronous active-high reset
// Notes: Command codes double as register addresses on the command port
`default_nettype none

package tlfr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] CODE_HOT_ALERT = 8'h51;
	localparam logic [7:0] CODE_COLD_ALERT = 8'h52;
	localparam logic [7:0] CODE_COLD_TRIP = 8'h53;
	localparam logic [7:0] CODE_COLD_ACTION = 8'h54;
	localparam logic [7:0] CODE_STATUS = 8'he0;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [15:0] RST_HOT_ALERT = 16'h0000;
	localparam logic [15:0] RST_COLD_ALERT = 16'h0000;
	localparam logic [15:0] RST_COLD_TRIP = 16'h0000;
	localparam logic [7:0] RST_COLD_ACTION = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions of the action byte
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DELAY_HI = 2;
	localparam int DELAY_LO = 0;

	// Status bit positions
	localparam int ST_HOT_WARN = 0;
	localparam int ST_COLD_WARN = 1;
	localparam int ST_COLD_FAULT = 2;

	// Retry codes
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// Widths of counters
	localparam int UNIT_W = 24;
	localparam int DLY_W = 8;
	localparam logic [DLY_W-1:0] DLY_ONE = 8'h01;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		MODE_IGNORE = 2'b00,
		MODE_RUN_DELAY = 2'b01,
		MODE_OFF_RETRY = 2'b10,
		MODE_OFF_LATCH = 2'b11
	} tlfr_mode_e;

	typedef enum logic [2:0] {
		FSM_RUN = 3'b000,
		FSM_GRACE = 3'b001,
		FSM_WAIT = 3'b010,
		FSM_LATCH = 3'b011
	} tlfr_fsm_e;

endpackage : tlfr_pkg

`default_nettype wire

/* File: test/tlfr_host.sv */
// Purpose: Host controller model driving the command port of the cold-trip block
// Assumes: Requests change at the falling edge and are held one full cycle
// Notes: Released lines carry inverted data so stale values never look valid
`default_nettype none

module tlfr_host (
	// Clock
	input wire logic clk_in,
	// Command requests
	output logic cmd_valid_out,
	output logic cmd_write_out,
	output logic [7:0] cmd_code_out,
	output logic [15:0] cmd_wdata_out,
	output logic clear_faults_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = 8'h00;
		cmd_wdata_out = 16'h0000;
		clear_faults_out = 1'b0;
	end

	// One whole word per request
	task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] d);
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = w;
		cmd_code_out = code;
		cmd_wdata_out = d;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		cmd_write_out = ~w;
		cmd_code_out = ~code;
		cmd_wdata_out = ~d;
	endtask : xfer

	// Write then read back of one code in adjacent cycles
	task automatic wr_rd(input logic [7:0] code, input logic [15:0] d);
		@(negedge clk_in);
		cmd_valid_out = 1'b1;
		cmd_write_out = 1'b1;
		cmd_code_out = code;
		cmd_wdata_out = d;
		@(negedge clk_in);
		cmd_write_out = 1'b0;
		cmd_wdata_out = ~d;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		cmd_write_out = 1'b1;
		cmd_code_out = ~code;
	endtask : wr_rd

	// Clear-all command pulse
	task automatic clear_all();
		@(negedge clk_in);
		clear_faults_out = 1'b1;
		@(negedge clk_in);
		clear_faults_out = 1'b0;
	endtask : clear_all

endmodule : tlfr_host

`default_nettype wire

/* File: test/tlfr_top_test.sv */
// Purpose: Self-checking bench of thresholds, status flags and cold-trip response
// Assumes: Delay unit of a few cycles keeps every fault sequence short
// Notes: Command results checked through a queue of expected answers
`default_nettype none

module tlfr_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_in, srst_in, c_valid, c_write, clr, c_ack, c_err, t_valid, on_off, shut, oe;
	logic [7:0] c_code;
	logic [15:0] c_wdata, c_rdata, temp, wv;
	logic [23:0] unit_len;
	logic [2:0] status;
	logic [16:0] exp_q[$];
	logic [7:0] codes [4] = '{8'h51, 8'h52, 8'h53, 8'h54};
	int miscompares, compares, rises, gap;

	tlfr_host u_host (.clk_in(clk_in), .cmd_valid_out(c_valid), .cmd_write_out(c_write),
		.cmd_code_out(c_code), .cmd_wdata_out(c_wdata), .clear_faults_out(clr));

	tlfr_top u_dut (.clk_in(clk_in), .srst_in(srst_in), .cmd_valid_in(c_valid),
		.cmd_write_in(c_write), .cmd_code_in(c_code), .cmd_wdata_in(c_wdata),
		.clear_faults_in(clr), .cmd_ack_out(c_ack), .cmd_err_out(c_err),
		.cmd_rdata_out(c_rdata), .temp_valid_in(t_valid), .temp_in(temp), .on_off_in(on_off),
		.other_shutdown_in(shut), .unit_len_in(unit_len), .out_enable_out(oe),
		.status_out(status));

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Counts: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cmd(input logic w, input logic [7:0] code, input logic [15:0] d,
		input logic [16:0] e);
		exp_q.push_back(e);
		u_host.xfer(w, code, d);
	endtask : cmd

	task automatic sample(input logic [15:0] t);
		@(negedge clk_in);
		t_valid = 1'b1;
		temp = t;
		@(negedge clk_in);
		t_valid = 1'b0;
		temp = ~t;
	endtask : sample

	task automatic wait_oe();
		int n;
		n = 0;
		while (oe !== 1'b1) begin
			@(negedge clk_in);
			n++;
			if (n > 500) begin
				miscompares++;
				$display("[ERR] %0t output never enabled", $time);
				stop_test();
			end
		end
	endtask : wait_oe

	// Healthy sample, clear-all, output back on
	task automatic recover();
		sample(16'h0032);
		u_host.clear_all();
		wait_oe();
	endtask : recover

	task automatic watch(input int cyc);
		logic prev;
		int last;
		prev = oe;
		rises = 0;
		gap = 0;
		last = 0;
		for (int i = 1; i <= cyc; i++) begin
			@(negedge clk_in);
			if (oe === 1'b1 && prev !== 1'b1) begin
				if (rises > 0) gap = i - last;
				rises++;
				last = i;
			end
			prev = oe;
		end
	endtask : watch

	////////////////////////////////////////////////////////////////////////////
	always @(negedge clk_in) begin
		if (c_ack === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(17'h1ffff, 17'h00000);
			end else begin
				check({c_err, c_rdata}, exp_q.pop_front());
			end
		end
	end

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	initial begin
		#1500000;
		miscompares++;
		stop_test();
	end

	initial begin
		srst_in = 1'b1;
		t_valid = 1'b0;
		temp = 16'h0000;
		on_off = 1'b0;
		shut = 1'b0;
		unit_len = 24'h000001;
		void'($urandom(31));
		repeat (20) @(negedge clk_in);
		srst_in = 1'b0;
		for (int i = 0; i < 4; i++) cmd(1'b0, codes[i], 16'h0000, 17'h00000);
		cmd(1'b0, tlfr_pkg::CODE_STATUS, 16'h0000, 17'h00000);
		cmd(1'b0, 8'h55, 16'h0000, 17'h10000);
		$display("Test reset values done");
		for (int i = 0; i < 4; i++) begin
			wv = 16'($urandom());
			exp_q.push_back(17'h00000);
			exp_q.push_back({1'b0, (i == 3) ? {8'h00, wv[7:0]} : wv});
			u_host.wr_rd(codes[i], wv);
		end
		$display("Test register access done");
		cmd(1'b1, tlfr_pkg::CODE_HOT_ALERT, 16'h0064, 17'h00000);
		cmd(1'b1, tlfr_pkg::CODE_COLD_ALERT, 16'h0005, 17'h00000);
		cmd(1'b1, tlfr_pkg::CODE_COLD_TRIP, 16'h0002, 17'h00000);
		cmd(1'b1, tlfr_pkg::CODE_COLD_ACTION, 16'h0000, 17'h00000);
		on_off = 1'b1;
		recover();
		sample(16'h00c8);
		check({14'h0000, status}, 17'h00001);
		cmd(1'b0, tlfr_pkg::CODE_STATUS, 16'h0000, 17'h00001);
		cmd(1'b1, tlfr_pkg::CODE_STATUS, 16'h0001, 17'h00000);
		sample(16'h0001);
		cmd(1'b0, tlfr_pkg::CODE_STATUS, 16'h0000, 17'h00006);
		watch(50);
		check({rises[15:0], oe}, 17'h00001);
		$display("Test flags and ignore mode done");
		recover();
		cmd(1'b1, tlfr_pkg::CODE_COLD_ACTION, 16'h00f8, 17'h00000);
		sample(16'h0001);
		watch(100);
		check({rises[15:0], oe}, 17'h00000);
		sample(16'h0032);
		cmd(1'b1, tlfr_pkg::CODE_STATUS, 16'h0004, 17'h00000);
		wait_oe();
		$display("Test latch mode done");
		for (int r = 0; r < 7; r++) begin
			recover();
			unit_len = 24'(r + 1);
			cmd(1'b1, tlfr_pkg::CODE_COLD_ACTION, {8'h00, 2'b10, 3'(r), 3'(r % 4)}, 17'h00000);
			sample(16'h0001);
			watch(300);
			check({rises[15:0], oe}, {16'(r), 1'b0});
			if (r > 1) begin
				check({16'h0000, gap >= (1 << (r % 4)) * (r + 1) &&
					gap <= (1 << (r % 4)) * (r + 1) + 5}, 17'h00001);
			end
		end
		$display("Test retry counts done");
		recover();
		unit_len = 24'h000004;
		cmd(1'b1, tlfr_pkg::CODE_COLD_ACTION, 16'h0042, 17'h00000);
		sample(16'h0001);
		watch(10);
		check({16'h0000, oe}, 17'h00001);
		watch(30);
		check({16'h0000, oe}, 17'h00000);
		$display("Test run-on mode done");
		recover();
		unit_len = 24'h000001;
		cmd(1'b1, tlfr_pkg::CODE_COLD_ACTION, 16'h00ba, 17'h00000);
		sample(16'h0001);
		watch(100);
		check({16'h0000, rises > 6}, 17'h00001);
		check({16'h0000, gap == 5}, 17'h00001);
		shut = 1'b1;
		watch(50);
		check({rises[15:0], oe}, 17'h00000);
		shut = 1'b0;
		sample(16'h0032);
		on_off = 1'b0;
		watch(10);
		on_off = 1'b1;
		wait_oe();
		$display("Test endless retry done");
		repeat (4) @(negedge clk_in);
		check({16'h0000, exp_q.size() == 0}, 17'h00001);
		stop_test();
	end

endmodule : tlfr_top_test

`default_nettype wire
